/* src/adri_top.sv */
// Added by the designer: the address-and-strobe port.
`include "adri_map.svh"
`default_nettype none
// playback front end: sample registers, rate interpolator, pin shifters
module adri_top (
	input  wire logic           CLK,
	input  wire logic           RST,
	input  wire logic           CRYSTAL_INPUT_CLOCK,
	input  wire adri_pkg::word_t ADDR,
	input  wire adri_pkg::word_t WDATA,
	input  wire logic           WR,
	input  wire logic           RD,
	output adri_pkg::word_t     RDATA,
	output logic                SAMPLE_REQ,
	output logic                LEFT_EXT_DATA_PIN,
	output logic                RIGHT_EXT_DATA_PIN,
	output logic                EXT_CONV_CLK,
	output logic                ANA_CLK_EN
);
	import adri_pkg::*;

	localparam logic [6:0] PRESC_NORM_LAST = 7'(`ADRI_PRESC_NORM - 1);
	localparam logic [6:0] PRESC_HIGH_LAST = 7'(`ADRI_PRESC_HIGH - 1);
	localparam logic [5:0] EXT_FAST_LAST   = 6'(`ADRI_EXT_FAST_HALF - 1);
	localparam logic [5:0] EXT_SLOW_LAST   = 6'(`ADRI_EXT_SLOW_HALF - 1);

	// ---------------- software registers ----------------
	word_t      rate_lo_ff, nxt_rate_lo;
	logic [3:0] rate_hi_ff, nxt_rate_hi;
	logic [7:0] left_lo_ff, nxt_left_lo;
	word_t      left_hi_ff, nxt_left_hi;
	logic [7:0] right_lo_ff, nxt_right_lo;
	word_t      right_hi_ff, nxt_right_hi;
	word_t      mode_ff, nxt_mode;
	word_t      rdata_ff, nxt_rdata;

	// ---------------- crystal synchroniser ----------------
	logic xs1_ff, nxt_xs1;
	logic xs2_ff, nxt_xs2;
	logic xs3_ff, nxt_xs3;

	// ---------------- rate engine ----------------
	logic [6:0] presc_ff, nxt_presc;
	rate_t      acc_ff, nxt_acc;
	logic [2:0] fcnt_ff, nxt_fcnt;
	logic       req_ff, nxt_req;

	// ---------------- converter clock ----------------
	logic [5:0] ediv_ff, nxt_ediv;
	logic       eclk_ff, nxt_eclk;
	logic       anaen_ff, nxt_anaen;

	// ---------------- decoded views ----------------
	rate_t      rate_word;
	logic       idle;
	logic       hi_rate;
	logic       slow_ext;
	logic [2:0] fine_tune_counter_limit;
	logic [6:0] fine_tune_increment_bits;
	logic       crystal_rise;
	logic [6:0] presc_last;
	logic       step;
	logic       extra;
	logic [20:0] sum;
	logic [5:0] ext_last;
	logic [7:0] inc_bits_ext;

	adri_ser_if left_if ();
	adri_ser_if right_if ();

	// rate word is the high nibble stacked on the low half
	assign rate_word = {rate_hi_ff, rate_lo_ff}; // RL1
	assign idle      = (rate_word == 20'h00000); // RL4
	assign hi_rate   = mode_ff[`ADRI_MODE_HIRATE_BIT];
	assign slow_ext  = mode_ff[`ADRI_MODE_EXTCLK_BIT];
	assign fine_tune_counter_limit  = mode_ff[`ADRI_MODE_LIM_MSB:`ADRI_MODE_LIM_LSB];
	assign fine_tune_increment_bits = mode_ff[`ADRI_MODE_INC_MSB:`ADRI_MODE_INC_LSB];

	// register writes; low-part registers keep only their upper byte
	always_comb begin
		nxt_rate_lo  = rate_lo_ff;
		nxt_rate_hi  = rate_hi_ff;
		nxt_left_lo  = left_lo_ff;
		nxt_left_hi  = left_hi_ff;
		nxt_right_lo = right_lo_ff;
		nxt_right_hi = right_hi_ff;
		nxt_mode     = mode_ff;
		if (WR) begin
			case (ADDR)
				`ADRI_OFS_RATE_LO:  nxt_rate_lo  = WDATA; // RL1
				`ADRI_OFS_RATE_HI:  nxt_rate_hi  = WDATA[`ADRI_RATE_HI_MSB:0]; // RL1
				`ADRI_OFS_LEFT_LO:  nxt_left_lo  = WDATA[`ADRI_LOWPART_MSB:`ADRI_LOWPART_LSB]; // RL6
				`ADRI_OFS_LEFT_HI:  nxt_left_hi  = WDATA; // RL6
				`ADRI_OFS_RIGHT_LO: nxt_right_lo = WDATA[`ADRI_LOWPART_MSB:`ADRI_LOWPART_LSB]; // RL6
				`ADRI_OFS_RIGHT_HI: nxt_right_hi = WDATA; // RL6
				// mode bits take effect at once; software keeps RL9 itself
				`ADRI_OFS_MODE:     nxt_mode     = WDATA & `ADRI_MODE_MASK; // RL9
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rate_lo_ff  <= `ADRI_RST_WORD;
			rate_hi_ff  <= `ADRI_RST_NIBBLE;
			left_lo_ff  <= `ADRI_RST_BYTE;
			left_hi_ff  <= `ADRI_RST_WORD;
			right_lo_ff <= `ADRI_RST_BYTE;
			right_hi_ff <= `ADRI_RST_WORD;
			mode_ff     <= `ADRI_RST_WORD;
		end else begin
			rate_lo_ff  <= nxt_rate_lo;
			rate_hi_ff  <= nxt_rate_hi;
			left_lo_ff  <= nxt_left_lo;
			left_hi_ff  <= nxt_left_hi;
			right_lo_ff <= nxt_right_lo;
			right_hi_ff <= nxt_right_hi;
			mode_ff     <= nxt_mode;
		end
	end

	// read data stands for exactly one cycle after the strobe, zero otherwise
	always_comb begin
		nxt_rdata = 16'h0000;
		if (RD) begin
			case (ADDR)
				`ADRI_OFS_RATE_LO:  nxt_rdata = rate_lo_ff;
				`ADRI_OFS_RATE_HI:  nxt_rdata = {12'h000, rate_hi_ff};
				`ADRI_OFS_LEFT_LO:  nxt_rdata = {left_lo_ff, 8'h00};
				`ADRI_OFS_LEFT_HI:  nxt_rdata = left_hi_ff;
				`ADRI_OFS_RIGHT_LO: nxt_rdata = {right_lo_ff, 8'h00};
				`ADRI_OFS_RIGHT_HI: nxt_rdata = right_hi_ff;
				`ADRI_OFS_MODE:     nxt_rdata = mode_ff;
				// live engine state: running, fine counter, shifters busy
				`ADRI_OFS_STATUS:   nxt_rdata = {10'h000, right_if.busy, left_if.busy,
				                                 fcnt_ff, ~idle};
				default:            nxt_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rdata_ff <= 16'h0000;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// crystal clock is foreign here: two flops, then a third for the edge
	always_comb begin
		nxt_xs1 = CRYSTAL_INPUT_CLOCK; // RL5
		nxt_xs2 = xs1_ff;
		nxt_xs3 = xs2_ff;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			xs1_ff <= 1'b0;
			xs2_ff <= 1'b0;
			xs3_ff <= 1'b0;
		end else begin
			xs1_ff <= nxt_xs1;
			xs2_ff <= nxt_xs2;
			xs3_ff <= nxt_xs3;
		end
	end

	// limitation: crystal must stay below CLK/2 or edges are lost
	assign crystal_rise = xs2_ff & ~xs3_ff; // RL5

	// prescale sets 2^27 (normal) or 2^26 (high rate) overall division
	assign presc_last = hi_rate ? PRESC_HIGH_LAST : PRESC_NORM_LAST; // RL3 RL8
	assign step       = crystal_rise & (presc_ff >= presc_last);
	// index 7 has no increment bit, so it never adds
	assign inc_bits_ext = {1'b0, fine_tune_increment_bits}; // RL11
	assign extra        = (fine_tune_counter_limit != 3'h0) && inc_bits_ext[fcnt_ff]; // RL11 RL12
	assign sum        = {1'b0, acc_ff} + {1'b0, rate_word} + {20'h00000, extra}; // RL2

	// interpolator: carry out of the 20-bit accumulator is the sample tick
	always_comb begin
		nxt_presc = presc_ff;
		nxt_acc   = acc_ff;
		nxt_fcnt  = fcnt_ff;
		nxt_req   = 1'b0;
		if (idle) begin
			nxt_presc = 7'h00; // RL4
			nxt_acc   = 20'h00000; // RL4
			nxt_fcnt  = 3'h0; // RL4
		end else if (crystal_rise) begin
			nxt_presc = step ? 7'h00 : presc_ff + 7'h01;
			if (step) begin
				nxt_acc = sum[19:0]; // RL2
				nxt_req = sum[20]; // RL16 RL7
				if (fine_tune_counter_limit == 3'h0) begin
					nxt_fcnt = 3'h0; // RL12
				end else if (fcnt_ff >= fine_tune_counter_limit) begin
					nxt_fcnt = 3'h0; // RL10
				end else begin
					nxt_fcnt = fcnt_ff + 3'h1; // RL10
				end
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			presc_ff <= 7'h00;
			acc_ff   <= 20'h00000;
			fcnt_ff  <= 3'h0;
			req_ff   <= 1'b0;
		end else begin
			presc_ff <= nxt_presc;
			acc_ff   <= nxt_acc;
			fcnt_ff  <= nxt_fcnt;
			req_ff   <= nxt_req;
		end
	end

	// the request pulse also loads both shifters with the held pair
	assign left_if.load  = req_ff; // RL16
	assign left_if.word  = {left_hi_ff, left_lo_ff}; // RL6
	assign right_if.load = req_ff; // RL16
	assign right_if.word = {right_hi_ff, right_lo_ff}; // RL6

	adri_serializer u_left (
		.clk (CLK),
		.rst (RST),
		.sif (left_if.ser)
	);

	adri_serializer u_right (
		.clk (CLK),
		.rst (RST),
		.sif (right_if.ser)
	);

	// converter clock: divided from CLK, so its rate is approximate
	assign ext_last = slow_ext ? EXT_SLOW_LAST : EXT_FAST_LAST; // RL13

	always_comb begin
		nxt_ediv  = ediv_ff;
		nxt_eclk  = eclk_ff;
		nxt_anaen = ~idle; // RL4
		if (idle) begin
			nxt_ediv = 6'h00; // RL4
			nxt_eclk = 1'b0; // RL4
		end else if (ediv_ff >= ext_last) begin
			nxt_ediv = 6'h00; // RL13
			nxt_eclk = ~eclk_ff; // RL13
		end else begin
			nxt_ediv = ediv_ff + 6'h01;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ediv_ff  <= 6'h00;
			eclk_ff  <= 1'b0;
			anaen_ff <= 1'b0;
		end else begin
			ediv_ff  <= nxt_ediv;
			eclk_ff  <= nxt_eclk;
			anaen_ff <= nxt_anaen;
		end
	end

	assign RDATA              = rdata_ff;
	assign SAMPLE_REQ         = req_ff; // RL7
	assign LEFT_EXT_DATA_PIN  = left_if.data; // RL14
	assign RIGHT_EXT_DATA_PIN = right_if.data; // RL14
	assign EXT_CONV_CLK       = eclk_ff;
	assign ANA_CLK_EN         = anaen_ff;
endmodule
`default_nettype wire

/* src/adri_map.svh */
// How it works
// [RL1] rate word is high nibble over low half
// [RL2] rate word accumulates; rollover marks each sample
// [RL3] normal mode: rate is crystal/2^27 times word
// [RL4] zero rate word idles logic and converter clock
// [RL5] accumulator paced by crystal clock, not PLL
// [RL6] 24-bit sample split: word plus low byte
// [RL7] sample request each period; software refills samples
// [RL8] high-rate mode bit: crystal/2^26 times word
// [RL9] software changes high-rate mode only while idle
// [RL10] limit field cycles counter zero to limit
// [RL11] set increment bit adds one at index
// [RL12] zero limit disables fine tuning entirely
// [RL13] mode bit selects 3 or 6 MHz clock
// [RL14] left/right data pins shift at 6 Mb/s
// [RL15] software programs fine tuning for exact rates
// [RL16] rollover raises request and consumes sample pair
`ifndef ADRI_MAP_SVH
`define ADRI_MAP_SVH

// register offsets
`define ADRI_OFS_RATE_LO        16'hFC34
`define ADRI_OFS_RATE_HI        16'hFC35
`define ADRI_OFS_LEFT_LO        16'hFC36
`define ADRI_OFS_LEFT_HI        16'hFC37
`define ADRI_OFS_RIGHT_LO       16'hFC38
`define ADRI_OFS_RIGHT_HI       16'hFC39
`define ADRI_OFS_STATUS         16'hFC3F
`define ADRI_OFS_MODE           16'hFED9

// reset values
`define ADRI_RST_WORD           16'h0000
`define ADRI_RST_NIBBLE         4'h0
`define ADRI_RST_BYTE           8'h00

// field positions
`define ADRI_RATE_HI_MSB        3
`define ADRI_LOWPART_MSB        15
`define ADRI_LOWPART_LSB        8
`define ADRI_MODE_EXTCLK_BIT    12
`define ADRI_MODE_HIRATE_BIT    11
`define ADRI_MODE_INC_MSB       10
`define ADRI_MODE_INC_LSB       4
`define ADRI_MODE_LIM_MSB       2
`define ADRI_MODE_LIM_LSB       0
`define ADRI_MODE_MASK          16'h1FF7

// timing
`define ADRI_CLK_HZ             200000000
`define ADRI_DATA_BPS           6000000
`define ADRI_BIT_CYC            (`ADRI_CLK_HZ / `ADRI_DATA_BPS)
`define ADRI_EXT_FAST_HZ        6000000
`define ADRI_EXT_SLOW_HZ        3000000
`define ADRI_EXT_FAST_HALF      (`ADRI_CLK_HZ / (2 * `ADRI_EXT_FAST_HZ))
`define ADRI_EXT_SLOW_HALF      (`ADRI_CLK_HZ / (2 * `ADRI_EXT_SLOW_HZ))
// crystal edges per accumulator step: 2^27/2^20 and 2^26/2^20
`define ADRI_PRESC_NORM         128
`define ADRI_PRESC_HIGH         64

`endif

/* src/adri_pkg.sv */
`default_nettype none
package adri_pkg;
	typedef logic [15:0] word_t;
	typedef logic [19:0] rate_t;
	typedef logic [23:0] sample_t;
	typedef enum logic [1:0] {
		SER_IDLE  = 2'b01,
		SER_SHIFT = 2'b10
	} ser_state_t;
endpackage
`default_nettype wire

/* src/adri_ser_if.sv */
`default_nettype none
// link between the rate engine and one data pin shifter
interface adri_ser_if;
	import adri_pkg::*;
	logic    load;
	sample_t word;
	logic    data;
	logic    busy;
	modport src (output load, output word, input data, input busy);
	modport ser (input load, input word, output data, output busy);
endinterface
`default_nettype wire

/* src/adri_serializer.sv */
`include "adri_map.svh"
`default_nettype none
// shifts one 24-bit sample out msb first at the pin bit rate
module adri_serializer (
	input wire logic clk,
	input wire logic rst,
	adri_ser_if.ser  sif
);
	import adri_pkg::*;

	localparam logic [5:0] BIT_LAST  = 6'(`ADRI_BIT_CYC - 1);
	localparam logic [4:0] LAST_BIT  = 5'h17;

	ser_state_t state_ff, nxt_state;
	sample_t    shreg_ff, nxt_shreg;
	logic [4:0] bitcnt_ff, nxt_bitcnt;
	logic [5:0] percnt_ff, nxt_percnt;
	logic       data_ff, nxt_data;

	// a new load restarts the word: a fresh sample outranks a stale tail
	always_comb begin
		nxt_state  = state_ff;
		nxt_shreg  = shreg_ff;
		nxt_bitcnt = bitcnt_ff;
		nxt_percnt = percnt_ff;
		nxt_data   = data_ff;
		if (sif.load) begin
			nxt_state  = SER_SHIFT;
			nxt_shreg  = sif.word;
			nxt_data   = sif.word[23];
			nxt_bitcnt = 5'h00;
			nxt_percnt = 6'h00;
		end else begin
			case (state_ff)
				SER_IDLE: begin
					nxt_data = 1'b0;
				end
				SER_SHIFT: begin
					if (percnt_ff >= BIT_LAST) begin // RL14
						nxt_percnt = 6'h00;
						if (bitcnt_ff == LAST_BIT) begin
							nxt_state = SER_IDLE;
							nxt_data  = 1'b0;
						end else begin
							nxt_bitcnt = bitcnt_ff + 5'h01;
							nxt_shreg  = {shreg_ff[22:0], 1'b0};
							nxt_data   = shreg_ff[22];
						end
					end else begin
						nxt_percnt = percnt_ff + 6'h01;
					end
				end
				default: begin
					nxt_state = SER_IDLE;
					nxt_data  = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff  <= SER_IDLE;
			shreg_ff  <= 24'h000000;
			bitcnt_ff <= 5'h00;
			percnt_ff <= 6'h00;
			data_ff   <= 1'b0;
		end else begin
			state_ff  <= nxt_state;
			shreg_ff  <= nxt_shreg;
			bitcnt_ff <= nxt_bitcnt;
			percnt_ff <= nxt_percnt;
			data_ff   <= nxt_data;
		end
	end

	assign sif.data = data_ff;
	assign sif.busy = (state_ff == SER_SHIFT);
endmodule
`default_nettype wire

/* verification/adri_top_chk.sv */
`default_nettype none
// port-level watch on the playback front end
module adri_top_chk (
	input wire logic            CLK,
	input wire logic            RST,
	input wire logic            RD,
	input wire adri_pkg::word_t RDATA,
	input wire logic            SAMPLE_REQ,
	input wire logic            LEFT_EXT_DATA_PIN,
	input wire logic            RIGHT_EXT_DATA_PIN,
	input wire logic            EXT_CONV_CLK,
	input wire logic            ANA_CLK_EN
);
	import adri_pkg::*;
	logic [9:0] cnt_ff;
	logic [9:0] nxt_cnt;

	// cycles since last request; parked high so reset looks like long idle
	always_comb begin
		nxt_cnt = (cnt_ff == 10'h3FF) ? cnt_ff : cnt_ff + 10'h001;
		if (SAMPLE_REQ)
			nxt_cnt = 10'h000;
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			cnt_ff <= 10'h3FF;
		else
			cnt_ff <= nxt_cnt;
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	sequence s_load;
		SAMPLE_REQ ##1 1'b1;
	endsequence
	sequence s_rise;
		$rose(EXT_CONV_CLK);
	endsequence

	// read data only in the slot after a read
	rd_slot_a: assert property (!RD |=> RDATA == 16'h0000)
		else $error("read data outside its slot");
	req_pulse_a: assert property (SAMPLE_REQ |=> !SAMPLE_REQ)
		else $error("request longer than one cycle");
	req_running_a: assert property (SAMPLE_REQ |-> ANA_CLK_EN)
		else $error("request while idle");
	idle_quiet_a: assert property (!ANA_CLK_EN [*3] |-> !SAMPLE_REQ && !EXT_CONV_CLK)
		else $error("activity while idle");
	// the first bit stands well beyond eight cycles after the load
	load_hold_a: assert property (s_load |=> ($stable(LEFT_EXT_DATA_PIN) && $stable(RIGHT_EXT_DATA_PIN)) [*8])
		else $error("first bit not held");
	frame_end_a: assert property (cnt_ff >= 10'h318 |-> !LEFT_EXT_DATA_PIN && !RIGHT_EXT_DATA_PIN)
		else $error("pins not low after frame");
	// idle may cut a high phase short, so the check stands down there
	clk_high_a: assert property (disable iff (RST || !ANA_CLK_EN) s_rise |-> EXT_CONV_CLK [*8])
		else $error("converter clock high too short");
	clk_low_a: assert property ($fell(EXT_CONV_CLK) |-> !EXT_CONV_CLK [*8])
		else $error("converter clock low too short");
	clk_half_a: assert property (s_rise |-> ##[17:34] !EXT_CONV_CLK)
		else $error("converter clock high too long");
endmodule

bind adri_top adri_top_chk u_chk (
	.CLK(CLK), .RST(RST), .RD(RD), .RDATA(RDATA), .SAMPLE_REQ(SAMPLE_REQ),
	.LEFT_EXT_DATA_PIN(LEFT_EXT_DATA_PIN), .RIGHT_EXT_DATA_PIN(RIGHT_EXT_DATA_PIN),
	.EXT_CONV_CLK(EXT_CONV_CLK), .ANA_CLK_EN(ANA_CLK_EN)
);
`default_nettype wire

/* verification/test_audio_dac_rate_interpolator.sv */
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module test_audio_dac_rate_interpolator;
	timeunit 1ns;
	timeprecision 1ps;
	import adri_pkg::*;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [1:0] xc = 2'h0;
	word_t      addr = 16'h0000;
	word_t      wdata = 16'h0000;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	word_t      rdata;
	logic       req;
	logic       lpin;
	logic       rpin;
	logic       eclk;
	logic       aen;
	int         fail_count = 0;
	int         tests_run = 0;
	int         nreq = 0;
	int         n;
	// mode first: it may only change while the rate word is still zero
	word_t      ofs[8] = '{16'hFED9, 16'hFC34, 16'hFC35, 16'hFC36,
	                       16'hFC37, 16'hFC38, 16'hFC39, 16'hFC3A};
	word_t      msk[8] = '{16'h1FF7, 16'hFFFF, 16'h000F, 16'hFF00,
	                       16'hFFFF, 16'hFF00, 16'hFFFF, 16'h0000};

	// 200 MHz core clock
	always #2.5 clk = ~clk;
	// crystal at a quarter of the core clock keeps sample periods short
	always @(posedge clk) begin
		xc <= xc + 2'h1;
	end
	// requests counted for the idle check
	always @(posedge clk) begin
		if (req === 1'b1)
			nreq <= nreq + 1;
	end

	adri_top u_dut (
		.CLK(clk), .RST(rst), .CRYSTAL_INPUT_CLOCK(xc[1]), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .SAMPLE_REQ(req), .LEFT_EXT_DATA_PIN(lpin),
		.RIGHT_EXT_DATA_PIN(rpin), .EXT_CONV_CLK(eclk), .ANA_CLK_EN(aen)
	);

	task automatic summarize;
		$display("mismatches %0d of %0d checks", fail_count, tests_run);
		if (fail_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic wrr(input word_t a, input word_t d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rdc(input word_t a, input word_t e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK(rdata, e)
	endtask

	// rate passes through zero around every mode change
	task automatic set_rate(input word_t m, input rate_t r);
		wrr(16'hFC35, 16'h0000);
		wrr(16'hFC34, 16'h0000);
		wrr(16'hFED9, m);
		wrr(16'hFC34, r[15:0]);
		wrr(16'hFC35, {12'h000, r[19:16]});
	endtask

	// edges until the next request; a hang ends the run
	task automatic wait_req(output int k);
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (req !== 1'b1 && k < 4000);
		if (req !== 1'b1) begin
			fail_count++;
			summarize();
		end
	endtask

	task automatic clk_to(input logic v, output int k);
		k = 0;
		while (eclk !== v && k < 100) begin
			@(posedge clk);
			#1;
			k++;
		end
		if (eclk !== v) begin
			fail_count++;
			summarize();
		end
	endtask

	// mid-bit samples of both pins, then the idle level
	task automatic chk_frame(input sample_t l, input sample_t r);
		for (int i = 24; i >= 0; i--) begin
			repeat (i == 24 ? 17 : 33) @(posedge clk);
			#1;
			`CHK({lpin, rpin}, (i > 0) ? {l[i-1], r[i-1]} : 2'b00)
		end
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		foreach (ofs[i]) rdc(ofs[i], 16'h0000);
		rdc(16'hFC3F, 16'h0000);
		repeat (3000) @(posedge clk);
		#1;
		`CHK({nreq, aen, eclk}, {32'h0, 2'b00})
		foreach (ofs[i]) wrr(ofs[i], 16'hFFFF);
		foreach (ofs[i]) rdc(ofs[i], msk[i]);
		// sample pair reaches the pins and is taken again at each rollover
		wrr(16'hFC36, 16'h3C00);
		wrr(16'hFC37, 16'hA5C3);
		wrr(16'hFC38, 16'hC100);
		wrr(16'hFC39, 16'h5A96);
		set_rate(16'h0000, 20'h80000);
		wait_req(n);
		chk_frame(24'hA5C33C, 24'h5A96C1);
		wrr(16'hFC37, 16'h0F0F);
		wait_req(n);
		chk_frame(24'h0F0F3C, 24'h5A96C1);
		wait_req(n);
		wait_req(n);
		`CHK(n, 32'h400)
		// just after a load: running, counter parked, both shifters busy
		rdc(16'hFC3F, 16'h0031);
		`CHK(aen, 1'b1)
		set_rate(16'h0800, 20'h80000);
		wait_req(n);
		wait_req(n);
		`CHK(n, 32'h200)
		clk_to(1'b0, n);
		clk_to(1'b1, n);
		clk_to(1'b0, n);
		`CHK(n, 32'h10)
		set_rate(16'h1000, 20'h80000);
		clk_to(1'b1, n);
		clk_to(1'b0, n);
		`CHK(n, 32'h21)
		// a third of a rollover: extras every step give three steps, not four
		set_rate(16'h0072, 20'h55555);
		wait_req(n);
		`CHK(n >= 1500 && n <= 1600, 1'b1)
		set_rate(16'h0070, 20'h55555);
		wait_req(n);
		`CHK(n >= 2000 && n <= 2100, 1'b1)
		set_rate(16'h0000, 20'h00000);
		summarize();
	end
endmodule
`default_nettype wire
